/* rtl/asc_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_OFF_MODE      3'h0
`define ASC_OFF_CTRL0     3'h1
`define ASC_OFF_CTRL1     3'h2
`define ASC_OFF_BRG       3'h3
`define ASC_OFF_TXBUF_LO  3'h4
`define ASC_OFF_TXBUF_HI  3'h5
`define ASC_OFF_RXBUF_LO  3'h6
`define ASC_OFF_RXBUF_HI  3'h7
`define ASC_MODE_EXTCLK   3
`define ASC_MODE_STOP2    4
`define ASC_MODE_ODD      5
`define ASC_MODE_PAREN    6
`define ASC_MODE_SLEEP    7
`define ASC_C0_CS0        0
`define ASC_C0_CS1        1
`define ASC_C0_RTSSEL     2
`define ASC_C0_IDLE       3
`define ASC_C0_HSOFF      4
`define ASC_C0_TXS        5
`define ASC_C1_TE         0
`define ASC_C1_TI         1
`define ASC_C1_RE         2
`define ASC_C1_RI         3
`define ASC_C1_OER        4
`define ASC_C1_FER        5
`define ASC_C1_PER        6
`define ASC_C1_SUM        7
`define ASC_RST_MODE      8'h00
`define ASC_RST_CTRL0     8'h08
`define ASC_RST_CTRL1     8'h02
`define ASC_RST_BRG       8'h00
`define ASC_PHASES        4'hf
`define ASC_MID_PHASE     4'h7
`endif

/* rtl/asc_pkg.sv */
// types shared by the serial channel modules
package asc_pkg;
	typedef enum logic [3:0] {
		ASC_TX_IDLE  = 4'b0001,
		ASC_TX_START = 4'b0010,
		ASC_TX_SHIFT = 4'b0100,
		ASC_TX_STOP  = 4'b1000
	} asc_tx_state_t;
	typedef enum logic [3:0] {
		ASC_RX_IDLE  = 4'b0001,
		ASC_RX_START = 4'b0010,
		ASC_RX_SHIFT = 4'b0100,
		ASC_RX_STOP  = 4'b1000
	} asc_rx_state_t;
	typedef struct packed {
		logic [3:0] nbits;
		logic       par_en;
		logic       odd;
		logic       stop2;
	} asc_fmt_t;
endpackage : asc_pkg

/* rtl/asc_tick_if.sv */
// sixteen-per-bit sampling tick and frame format shared by the channel modules
`timescale 1ns/1ps
`default_nettype none
interface asc_tick_if;
	import asc_pkg::*;
	logic     tick16;
	asc_fmt_t fmt;
	modport src (output tick16, output fmt);
	modport dst (input tick16, input fmt);
endinterface : asc_tick_if
`default_nettype wire

/* rtl/asc_baud_gen.sv */
// bit-rate divider: selected clock divided by n+1
`timescale 1ns/1ps
`default_nettype none
module asc_baud_gen #(
	parameter int PRE_W = 4
) (
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	// source selection
	input  wire logic       i_ext_sel,
	input  wire logic [1:0] i_int_sel,
	input  wire logic       i_ext_rise,
	input  wire logic [7:0] i_brg,
	// tick out
	output logic            o_tick
);
	logic [PRE_W-1:0] pre_q;
	logic [7:0]       cnt_q;
	logic             src_en;
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			pre_q <= '0;
		else
			pre_q <= pre_q + 1'b1;
	end
	// internal prescaled sources: f1, f/2, f/4, f/8 style enables
	always_comb begin
		if (i_ext_sel) begin
			src_en = i_ext_rise;
		end else begin
			unique case (i_int_sel)
				2'd0: src_en = 1'b1;
				2'd1: src_en = &pre_q[0:0];
				2'd2: src_en = &pre_q[1:0];
				default: src_en = &pre_q[2:0];
			endcase
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			cnt_q <= 8'h00;
		else if (src_en)
			cnt_q <= (cnt_q == 8'h00) ? i_brg : cnt_q - 8'h01;
	end
	assign o_tick = src_en && (cnt_q == 8'h00);
endmodule : asc_baud_gen
`default_nettype wire

/* rtl/asc_rx.sv */
// receive shifter with sixteen-phase start-relative sampling
`timescale 1ns/1ps
`default_nettype none
module asc_rx
	import asc_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	// control
	asc_tick_if.dst         tk,
	input  wire logic       i_enable,
	input  wire logic       i_rxd,
	// result
	output logic            o_busy,
	output logic            o_done,
	output logic [8:0]      o_data,
	output logic            o_fer,
	output logic            o_per
);
	`include "asc_regs.svh"
	asc_rx_state_t st_q;
	logic [3:0]    ph_q;
	logic [3:0]    idx_q;
	logic [8:0]    sh_q;
	logic          par_q;
	logic          stop2_q;
	logic [3:0]    total;
	logic          mid;
	assign total = tk.fmt.nbits + {3'h0, tk.fmt.par_en};
	assign mid = tk.tick16 && (ph_q == `ASC_MID_PHASE);
	assign o_busy = (st_q != ASC_RX_IDLE);
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst || !i_enable) begin
			st_q   <= ASC_RX_IDLE;
			ph_q   <= 4'h0;
			idx_q  <= 4'h0;
			sh_q   <= 9'h000;
			par_q  <= 1'b0;
			stop2_q <= 1'b0;
			o_done <= 1'b0;
			o_data <= 9'h000;
			o_fer  <= 1'b0;
			o_per  <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (tk.tick16 && st_q != ASC_RX_IDLE)
				ph_q <= ph_q + 4'h1;
			unique case (st_q)
				ASC_RX_IDLE: if (!i_rxd) begin
					st_q <= ASC_RX_START;
					ph_q <= 4'h0;
				end
				ASC_RX_START: if (mid) begin
					if (i_rxd) begin
						st_q <= ASC_RX_IDLE;
					end else begin
						st_q  <= ASC_RX_SHIFT;
						idx_q <= 4'h0;
						par_q <= 1'b0;
					end
				end
				ASC_RX_SHIFT: if (mid) begin
					if (idx_q < tk.fmt.nbits)
						sh_q[idx_q] <= i_rxd;
					par_q <= par_q ^ i_rxd;
					idx_q <= idx_q + 4'h1;
					if (idx_q + 4'h1 == total) begin
						st_q    <= ASC_RX_STOP;
						stop2_q <= 1'b0;
						o_fer   <= 1'b0;
					end
				end
				ASC_RX_STOP: if (mid) begin
					if (!i_rxd)
						o_fer <= 1'b1;
					if (tk.fmt.stop2 && !stop2_q && i_rxd) begin
						stop2_q <= 1'b1;
					end else begin
						st_q   <= ASC_RX_IDLE;
						o_done <= 1'b1;
						o_data <= sh_q;
						o_per  <= tk.fmt.par_en && (par_q ^ tk.fmt.odd) == 1'b0 ? 1'b0 :
							tk.fmt.par_en;
					end
				end
			endcase
		end
	end
endmodule : asc_rx
`default_nettype wire

/* rtl/asc_channel.sv */
// asynchronous serial channel: registers, transmitter, handshake
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - mode bit 3 picks external clock
// - control0 bits 1:0 pick internal prescale
// - divide by n+1 then by 16
// - stop count, parity enable, odd/even parity
// - control0 bit 2: CTS in or RTS out
// - control0 bit 4 disables handshake
// - control0 bit 5 selects open-drain transmit
// - start needs enable, buffer full, CTS low
// - start, data lsb first, parity, stops
// - buffer-empty flag clear on write, set on load
// - next buffer auto-loads after frame ends
// - started frame ignores enable and CTS
// - start checked during frame-end strobe
// - idle flag sets cycle after frame end
// - receiver counts from start-bit edge
// - RTS low when ready, high receiving
// - full frame to buffer sets receive-full
// - overrun when buffer still full
// - framing, parity, summary error flags
// - flag clearing by read or disable
// - sleep drops characters with top bit 0
module asc_channel
	import asc_pkg::*;
#(
	parameter int  PRE_W     = 4,
	parameter bit  HAS_TXS   = 1'b1
) (
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_nrst,
	// register port
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata,
	// pins
	input  wire logic       i_rxd,
	input  wire logic       i_clk_pin,
	input  wire logic       i_cts_n,
	input  wire logic       i_serial_sel,
	output logic            o_txd,
	output logic            o_txd_oe_n,
	output logic            o_rts_n,
	output logic            o_rts_oe_n,
	output logic            o_clk_pin_used,
	// events
	output logic            o_tx_req,
	output logic            o_rx_req
);
	`include "asc_regs.svh"
	asc_tick_if tk ();
	logic [7:0] mode_q, ctrl0_q, brg_q;
	logic       tx_enable_flag_q, tx_buffer_empty_flag_q, rx_enable_flag_q;
	logic       rx_full_flag_q, overrun_flag_q, framing_error_flag_q, parity_error_flag_q;
	logic       tx_idle_flag_q;
	logic [8:0] txbuf_q, rxbuf_q;
	logic [2:0] rxd_s_q, clk_s_q, cts_s_q;
	logic       rxd_s, cts_s, ext_rise;
	logic       tick_pre;
	logic [3:0] div16_q;
	logic       bit_tick;
	asc_tx_state_t tx_st_q;
	logic [3:0] tx_ph_q;
	logic [3:0] tx_idx_q;
	logic [8:0] tx_sh_q;
	logic       tx_par_q;
	logic       tx_stop2_q;
	logic       frame_end_strobe;
	logic       start_ok;
	logic       wr_tx, rd_rxlo, re_off;
	logic       rx_busy, rx_done, rx_fer, rx_per;
	logic [8:0] rx_data;
	logic       accept;
	logic       cts_sel, rts_sel;
	logic       rts_ready_q;
	function automatic logic [3:0] fmt_bits(input logic [2:0] m);
		unique case (m)
			3'b100:  fmt_bits = 4'd7;
			3'b110:  fmt_bits = 4'd9;
			default: fmt_bits = 4'd8;
		endcase
	endfunction : fmt_bits
	// pin synchronisers; only stage 2 and later are read
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			rxd_s_q <= 3'b111;
			clk_s_q <= 3'b000;
			cts_s_q <= 3'b111;
		end else begin
			rxd_s_q <= {rxd_s_q[1:0], i_rxd};
			clk_s_q <= {clk_s_q[1:0], i_clk_pin};
			cts_s_q <= {cts_s_q[1:0], i_cts_n};
		end
	end
	assign rxd_s    = rxd_s_q[1];
	assign cts_s    = cts_s_q[1];
	assign ext_rise = clk_s_q[1] && !clk_s_q[2];
	asc_baud_gen #(.PRE_W(PRE_W)) u_baud (
		.i_clk_sys  (i_clk_sys),
		.i_nrst     (i_nrst),
		.i_ext_sel  (mode_q[`ASC_MODE_EXTCLK]),
		.i_int_sel  (ctrl0_q[`ASC_C0_CS1:`ASC_C0_CS0]),
		.i_ext_rise (ext_rise),
		.i_brg      (brg_q),
		.o_tick     (tick_pre)
	);
	assign tk.tick16       = tick_pre;
	assign tk.fmt.nbits    = fmt_bits(mode_q[2:0]);
	assign tk.fmt.par_en   = mode_q[`ASC_MODE_PAREN];
	assign tk.fmt.odd      = mode_q[`ASC_MODE_ODD];
	assign tk.fmt.stop2    = mode_q[`ASC_MODE_STOP2];
	assign o_clk_pin_used  = mode_q[`ASC_MODE_EXTCLK];
	// handshake selection
	assign cts_sel = !ctrl0_q[`ASC_C0_HSOFF] && !ctrl0_q[`ASC_C0_RTSSEL];
	assign rts_sel = !ctrl0_q[`ASC_C0_HSOFF] && ctrl0_q[`ASC_C0_RTSSEL];
	// bus decode
	assign wr_tx   = i_wr && (i_addr == `ASC_OFF_TXBUF_LO);
	assign rd_rxlo = i_rd && (i_addr == `ASC_OFF_RXBUF_LO);
	assign re_off  = (i_wr && i_addr == `ASC_OFF_CTRL1 && !i_wdata[`ASC_C1_RE]) ||
		!i_serial_sel;
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			mode_q  <= `ASC_RST_MODE;
			ctrl0_q <= `ASC_RST_CTRL0 & 8'h37;
			brg_q   <= `ASC_RST_BRG;
		end else if (i_wr) begin
			if (i_addr == `ASC_OFF_MODE)
				mode_q <= i_wdata;
			if (i_addr == `ASC_OFF_CTRL0)
				ctrl0_q <= i_wdata & (HAS_TXS ? 8'h37 : 8'h17);
			if (i_addr == `ASC_OFF_BRG)
				brg_q <= i_wdata;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			tx_enable_flag_q <= 1'b0;
			rx_enable_flag_q <= 1'b0;
		end else if (i_wr && i_addr == `ASC_OFF_CTRL1) begin
			tx_enable_flag_q <= i_wdata[`ASC_C1_TE];
			rx_enable_flag_q <= i_wdata[`ASC_C1_RE];
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			txbuf_q <= 9'h000;
		else if (wr_tx)
			txbuf_q[7:0] <= i_wdata;
		else if (i_wr && i_addr == `ASC_OFF_TXBUF_HI)
			txbuf_q[8] <= i_wdata[0];
	end
	// divide tick by 16 into the transmit bit clock
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			div16_q <= 4'h0;
		else if (tick_pre)
			div16_q <= div16_q + 4'h1;
	end
	assign bit_tick = tick_pre && (div16_q == `ASC_PHASES);
	// frame end strobe: high on a bit tick while idle or on the last bit tick of stop
	// idle loads wait for a bit tick so the start bit is a full bit long
	assign frame_end_strobe = (tx_st_q == ASC_TX_IDLE && bit_tick) ||
		(tx_st_q == ASC_TX_STOP && bit_tick && (!tk.fmt.stop2 || tx_stop2_q));
	assign start_ok = tx_enable_flag_q && !tx_buffer_empty_flag_q &&
		(!cts_sel || !cts_s);
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			tx_st_q   <= ASC_TX_IDLE;
			tx_ph_q   <= 4'h0;
			tx_idx_q  <= 4'h0;
			tx_sh_q   <= 9'h1ff;
			tx_par_q  <= 1'b0;
			tx_stop2_q <= 1'b0;
			o_txd     <= 1'b1;
		end else if (frame_end_strobe && start_ok) begin
			tx_st_q  <= ASC_TX_START;
			tx_sh_q  <= txbuf_q;
			tx_idx_q <= 4'h0;
			tx_par_q <= 1'b0;
			o_txd    <= 1'b0;
		end else if (frame_end_strobe) begin
			tx_st_q <= ASC_TX_IDLE;
			o_txd   <= 1'b1;
		end else if (bit_tick) begin
			unique case (tx_st_q)
				ASC_TX_START, ASC_TX_SHIFT: begin
					if (tx_idx_q < tk.fmt.nbits) begin
						o_txd    <= tx_sh_q[tx_idx_q];
						tx_par_q <= tx_par_q ^ tx_sh_q[tx_idx_q];
						tx_idx_q <= tx_idx_q + 4'h1;
						tx_st_q  <= ASC_TX_SHIFT;
					end else if (tk.fmt.par_en && tx_st_q == ASC_TX_SHIFT &&
							tx_idx_q == tk.fmt.nbits) begin
						o_txd    <= tx_par_q ^ tk.fmt.odd;
						tx_idx_q <= tx_idx_q + 4'h1;
					end else begin
						o_txd      <= 1'b1;
						tx_st_q    <= ASC_TX_STOP;
						tx_stop2_q <= 1'b0;
					end
				end
				ASC_TX_STOP: tx_stop2_q <= 1'b1;
				default: tx_st_q <= ASC_TX_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			tx_buffer_empty_flag_q <= 1'b1;
		else if (frame_end_strobe && start_ok)
			tx_buffer_empty_flag_q <= 1'b1;
		else if (wr_tx)
			tx_buffer_empty_flag_q <= 1'b0;
	end
	assign o_tx_req = frame_end_strobe && start_ok;
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			tx_idle_flag_q <= 1'b1;
		else if (frame_end_strobe && start_ok)
			tx_idle_flag_q <= 1'b0;
		else if (frame_end_strobe)
			tx_idle_flag_q <= 1'b1;
	end
	assign o_txd_oe_n = (ctrl0_q[`ASC_C0_TXS] && HAS_TXS) ? o_txd : 1'b0;
	asc_rx u_rx (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.tk        (tk.dst),
		.i_enable  (rx_enable_flag_q && i_serial_sel),
		.i_rxd     (rxd_s),
		.o_busy    (rx_busy),
		.o_done    (rx_done),
		.o_data    (rx_data),
		.o_fer     (rx_fer),
		.o_per     (rx_per)
	);
	// sleep: top data bit zero is dropped
	assign accept = rx_done && (!mode_q[`ASC_MODE_SLEEP] ||
		rx_data[tk.fmt.nbits - 4'h1]);
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			rxbuf_q              <= 9'h000;
			rx_full_flag_q       <= 1'b0;
			overrun_flag_q       <= 1'b0;
			framing_error_flag_q <= 1'b0;
			parity_error_flag_q  <= 1'b0;
		end else if (accept) begin
			rxbuf_q              <= rx_data;
			rx_full_flag_q       <= 1'b1;
			overrun_flag_q       <= overrun_flag_q | rx_full_flag_q;
			framing_error_flag_q <= rx_fer;
			parity_error_flag_q  <= rx_per;
		end else if (re_off) begin
			rx_full_flag_q       <= 1'b0;
			overrun_flag_q       <= 1'b0;
			framing_error_flag_q <= 1'b0;
			parity_error_flag_q  <= 1'b0;
		end else if (rd_rxlo) begin
			rx_full_flag_q       <= 1'b0;
			framing_error_flag_q <= 1'b0;
			parity_error_flag_q  <= 1'b0;
		end
	end
	assign o_rx_req = accept && !rx_full_flag_q;
	// rts: ready after enable, busy during frame, ready after transfer
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			rts_ready_q <= 1'b0;
		else if (!rx_enable_flag_q)
			rts_ready_q <= 1'b0;
		else if (rx_busy && !rx_done)
			rts_ready_q <= 1'b0;
		else
			rts_ready_q <= 1'b1;
	end
	assign o_rts_n    = !(rts_sel && rts_ready_q);
	assign o_rts_oe_n = !rts_sel;
	// register read, one cycle later
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				`ASC_OFF_MODE:     o_rdata <= mode_q;
				`ASC_OFF_CTRL0:    o_rdata <= {ctrl0_q[7:4], tx_idle_flag_q, ctrl0_q[2:0]};
				`ASC_OFF_CTRL1:    o_rdata <= {overrun_flag_q | framing_error_flag_q |
					parity_error_flag_q, parity_error_flag_q, framing_error_flag_q,
					overrun_flag_q, rx_full_flag_q, rx_enable_flag_q,
					tx_buffer_empty_flag_q, tx_enable_flag_q};
				`ASC_OFF_BRG:      o_rdata <= brg_q;
				`ASC_OFF_RXBUF_LO: o_rdata <= rxbuf_q[7:0];
				`ASC_OFF_RXBUF_HI: o_rdata <= {7'h00, rxbuf_q[8]};
				default:           o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule : asc_channel
`default_nettype wire

/* sim/asc_channel_properties.sv */
// assertion checker bound to the serial channel top
`timescale 1ns/1ps
`default_nettype none
module asc_channel_chk (
	// clock and reset
	input wire logic       i_clk_sys,
	input wire logic       i_nrst,
	// register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	// pins and events
	input wire logic       i_cts_n,
	input wire logic       o_txd,
	input wire logic       o_txd_oe_n,
	input wire logic       o_rts_n,
	input wire logic       o_rts_oe_n,
	input wire logic       o_clk_pin_used,
	input wire logic       o_tx_req,
	input wire logic       o_rx_req
);
	logic [7:0] md_q;
	logic [7:0] c0_q;
	logic       te_q;
	logic       re_q;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// shadow of written control fields
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			md_q <= 8'h00;
			c0_q <= 8'h08;
			te_q <= 1'b0;
			re_q <= 1'b0;
		end else if (i_wr) begin
			if (i_addr == 3'h0) md_q <= i_wdata;
			if (i_addr == 3'h1) c0_q <= i_wdata;
			if (i_addr == 3'h2) te_q <= i_wdata[0];
			if (i_addr == 3'h2) re_q <= i_wdata[2];
		end
	end
	clk_pin_a: assert property ($stable(md_q[3]) |-> o_clk_pin_used == md_q[3])
		else $error("clock pin use wrong");
	txd_drive_a: assert property ($stable(c0_q[5]) |-> o_txd_oe_n == (c0_q[5] & o_txd))
		else $error("transmit driver mode wrong");
	rts_enable_a: assert property ($stable(c0_q) |-> o_rts_oe_n == !(c0_q[2] & !c0_q[4]))
		else $error("handshake pin enable wrong");
	rts_idle_a: assert property (c0_q[2] && !re_q && !$past(re_q) |-> o_rts_n)
		else $error("request line low while disabled");
	load_enable_a: assert property (o_tx_req |-> te_q || $past(te_q))
		else $error("load without transmit enable");
	load_cts_a: assert property (o_tx_req && !c0_q[2] && !c0_q[4] |-> !$past(i_cts_n, 2))
		else $error("load while clear-to-send high");
	start_bit_a: assert property (o_tx_req |-> ##[0:64] !o_txd)
		else $error("no start bit after load");
	bit_hold_a: assert property ($fell(o_txd) |-> !o_txd [*8])
		else $error("low bit too short");
	rx_enable_a: assert property (o_rx_req |-> re_q ##1 !o_rx_req)
		else $error("receive event wrong");
endmodule : asc_channel_chk
bind asc_channel asc_channel_chk u_chk (.i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr,
	.i_cts_n, .o_txd, .o_txd_oe_n, .o_rts_n, .o_rts_oe_n, .o_clk_pin_used, .o_tx_req,
	.o_rx_req);
`default_nettype wire

/* sim/asc_remote.sv */
// remote serial transceiver on the line side
`timescale 1ns/1ps
`default_nettype none
module asc_remote #(
	parameter int BIT = 32
) (
	// clock
	input  wire logic i_clk,
	// line
	input  wire logic i_line,
	output logic      o_rxd,
	output logic      o_cts_n
);
	logic [7:0] got[$];
	logic [7:0] sh;
	initial begin
		o_rxd = 1'b1;
		o_cts_n = 1'b1;
	end
	// eight data bits, no parity, sampled mid-bit
	always begin
		@(negedge i_line);
		repeat (BIT / 2) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge i_clk);
			sh[i] = i_line;
		end
		repeat (BIT) @(posedge i_clk);
		got.push_back(sh);
	end
	task automatic send(input logic [7:0] d, input logic par, input logic odd,
		input logic bad_par, input logic bad_stop);
		logic [10:0] f;
		f = {1'b1, !bad_stop, d, 1'b0};
		if (par) f = {!bad_stop, ^d ^ odd ^ bad_par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			o_rxd <= f[i];
			repeat (BIT) @(posedge i_clk);
		end
		o_rxd <= 1'b1;
	endtask : send
endmodule : asc_remote
`default_nettype wire

/* sim/asc_channel_tb_top.sv */
// self-checking bench for the serial channel
`timescale 1ns/1ps
`default_nettype none
module asc_channel_tb_top;
	logic       i_clk_sys;
	logic       i_nrst;
	logic [2:0] i_addr;
	logic [7:0] i_wdata;
	logic       i_wr;
	logic       i_rd;
	logic [7:0] o_rdata;
	logic       i_serial_sel;
	logic       i_rxd;
	logic       i_cts_n;
	logic       o_txd;
	logic       o_txd_oe_n;
	logic       o_rts_n;
	logic       o_tx_req;
	wire        line = o_txd_oe_n ? 1'b1 : o_txd;
	int         errors;
	int         check_count;
	asc_channel dut (.i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_rxd, .i_clk_pin(1'b0), .i_cts_n, .i_serial_sel, .o_txd, .o_txd_oe_n,
		.o_rts_n, .o_rts_oe_n(), .o_clk_pin_used(), .o_tx_req, .o_rx_req());
	asc_remote #(.BIT(32)) u_rem (.i_clk(i_clk_sys), .i_line(line), .o_rxd(i_rxd),
		.o_cts_n(i_cts_n));
	always #12.5 i_clk_sys = ~i_clk_sys;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		@(posedge i_clk_sys);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
		@(posedge i_clk_sys);
	endtask : rd
	task automatic wait_req(output int k);
		k = 0;
		while (o_tx_req !== 1'b1 && k < 2000) begin
			@(posedge i_clk_sys);
			#1 k++;
		end
		chk({7'h00, o_tx_req}, 8'h01);
		@(posedge i_clk_sys);
	endtask : wait_req
	task automatic wait_got(input int n);
		for (int k = 0; k < 4000 && u_rem.got.size() < n; k++) @(posedge i_clk_sys);
		chk(8'(u_rem.got.size()), 8'(n));
	endtask : wait_got
	task automatic rx_byte(input logic [7:0] d, input logic [3:0] m);
		u_rem.send(d, m[0], m[1], m[2], m[3]);
		repeat (40) @(posedge i_clk_sys);
	endtask : rx_byte
	task automatic t_tx();
		int k;
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h08);
		rd(3'h2, 8'h02);
		wr(3'h0, 8'h05);
		wr(3'h3, 8'h01);
		wr(3'h1, 8'h30);
		wr(3'h2, 8'h01);
		wr(3'h4, 8'ha5);
		wait_req(k);
		wr(3'h4, 8'h3c);
		rd(3'h1, 8'h30);
		wait_req(k);
		chk(8'(k > 305 && k < 326), 8'h01);
		wr(3'h2, 8'h00);
		wait_got(2);
		chk(u_rem.got[0], 8'ha5);
		chk(u_rem.got[1], 8'h3c);
		repeat (40) @(posedge i_clk_sys);
		rd(3'h1, 8'h38);
	endtask : t_tx
	task automatic t_cts();
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h01);
		wr(3'h4, 8'h81);
		repeat (200) @(posedge i_clk_sys);
		chk(8'(u_rem.got.size()), 8'h02);
		rd(3'h2, 8'h01);
		u_rem.o_cts_n <= 1'b0;
		wait_got(3);
		chk(u_rem.got[2], 8'h81);
	endtask : t_cts
	task automatic t_rx();
		wr(3'h1, 8'h04);
		wr(3'h2, 8'h04);
		#1 chk({7'h00, o_rts_n}, 8'h00);
		rx_byte(8'h5a, 4'h0);
		rd(3'h2, 8'h0e);
		chk({7'h00, o_rts_n}, 8'h00);
		rd(3'h6, 8'h5a);
		rd(3'h2, 8'h06);
		rx_byte(8'h11, 4'h0);
		rx_byte(8'h22, 4'h0);
		rd(3'h2, 8'h9e);
		rd(3'h6, 8'h22);
		rd(3'h2, 8'h96);
		wr(3'h2, 8'h00);
		rd(3'h2, 8'h02);
	endtask : t_rx
	task automatic t_err();
		wr(3'h0, 8'h45);
		wr(3'h2, 8'h04);
		rx_byte(8'h33, 4'h5);
		rd(3'h2, 8'hce);
		wr(3'h2, 8'h00);
		wr(3'h2, 8'h04);
		rx_byte(8'h0f, 4'h9);
		rd(3'h2, 8'hae);
		i_serial_sel <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_serial_sel <= 1'b1;
		@(posedge i_clk_sys);
		rd(3'h2, 8'h06);
		wr(3'h0, 8'h65);
		rx_byte(8'h44, 4'h3);
		rd(3'h2, 8'h0e);
		rd(3'h6, 8'h44);
	endtask : t_err
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		errors++;
		complete_run();
	end
	initial begin
		i_clk_sys = 1'b0;
		i_nrst = 1'b0;
		i_addr = 3'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_serial_sel = 1'b1;
		errors = 0;
		check_count = 0;
		repeat (10) @(posedge i_clk_sys);
		i_nrst <= 1'b1;
		@(posedge i_clk_sys);
		t_tx();
		t_cts();
		t_rx();
		t_err();
		complete_run();
	end
endmodule : asc_channel_tb_top
`default_nettype wire
